// ===== rtl/dacil_pkg.sv
package dacil_pkg;

  // ---------------------------------------------------------------
  // widths and codes
  // ---------------------------------------------------------------
  localparam int          DACIL_DATA_W    = 10;
  localparam int          DACIL_MSB_POS   = 9;
  localparam int          DACIL_LSB_POS   = 0;
  localparam logic [9:0]  DACIL_CODE_FS   = 10'h3FF;
  localparam logic [9:0]  DACIL_CODE_ZERO = 10'h000;
  localparam int          DACIL_PRI_DEN   = 1023;
  localparam int          DACIL_CMP_DEN   = 1024;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int          DACIL_CLK_PERIOD_NS = 10;
  localparam int          DACIL_SLEEP_DOWN_NS = 50;
  localparam int          DACIL_WAKE_US       = 5;
  // power-down is a longest time: round down
  localparam int          DACIL_DOWN_CYC      = DACIL_SLEEP_DOWN_NS / DACIL_CLK_PERIOD_NS;
  // wake is nominal: round up
  localparam int          DACIL_WAKE_CYC      =
    (DACIL_WAKE_US * 1000 + DACIL_CLK_PERIOD_NS - 1) / DACIL_CLK_PERIOD_NS;
  localparam int          DACIL_CNT_W         = 10;

  // ---------------------------------------------------------------
  // modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    DACIL_CLK_SINGLE = 2'b00,
    DACIL_CLK_DIFF   = 2'b01,
    DACIL_CLK_TERM   = 2'b10
  } dacil_clk_mode_t;

  typedef enum logic [1:0] {
    DACIL_PWR_ON    = 2'b00,
    DACIL_PWR_DOWN  = 2'b01,
    DACIL_PWR_SLEEP = 2'b10,
    DACIL_PWR_WAKE  = 2'b11
  } dacil_pwr_t;

  typedef struct packed {
    logic [9:0] primary;
    logic [9:0] complementary;
  } dacil_out_t;

  typedef struct packed {
    logic [9:0]       word;
    dacil_out_t       out;
    dacil_pwr_t       pwr;
    logic [9:0]       cnt;
    logic             powered;
    dacil_clk_mode_t  mode;
    logic             term_en;
    logic             neg_in_en;
  } dacil_state_t;

endpackage : dacil_pkg

// ===== rtl/dacil_core.sv
// Summary of operation
// - input word is 10-bit straight binary, bit 9 msb, bit 0 lsb
// - all ones gives full scale on primary; complementary carries remainder
// - word captured in master/slave latch, output updates on rising edge only
// - any clock duty cycle works if high and low phases meet width
// - receiver mode follows select pin: ground single, supply diff, float terminated
// - sleep high powers down, output current off, supply current cut
// - sleep input pulled down internally, unconnected means enabled
// - power down within 50 ns, back to normal in about 5 us
// - primary is code/1023 of full scale, complementary (1023-code)/1024
`timescale 1ns/1ps
`default_nettype none
module dacil_core
  import dacil_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // sample word
  input  wire logic [9:0]  data_word,
  // static straps: select tied low, tied high, floating
  input  wire logic        clock_receiver_select_low,
  input  wire logic        clock_receiver_select_high,
  // power control, high means sleep
  input  wire logic        sleep_in,
  input  wire logic        sleep_in_driven,
  // converter drive: codes steered to each current node
  output logic [9:0]       primary_current_out,
  output logic [9:0]       complementary_current_out,
  output logic             output_enabled,
  // receiver configuration
  output dacil_clk_mode_t  clk_mode,
  output logic             clk_term_en,
  output logic             clk_neg_in_en
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  dacil_state_t    state_reg;
  dacil_state_t    state_next;
  logic            sleep_eff;
  logic            down_done;
  logic            wake_done;
  logic            go_down;
  logic            go_sleep;
  logic            go_wake;
  logic            go_on;
  logic [9:0]      cap_lane;
  logic [9:0]      lane_pri;
  logic [9:0]      lane_cmp;
  dacil_clk_mode_t strap_mode;

  // ---------------------------------------------------------------
  // per-bit lanes
  // ---------------------------------------------------------------
  // each bit steers its source to one node or the other, so the
  // complementary code is the inverse: 1023 - code, no carry chain
  for (genvar b = 0; b < DACIL_DATA_W; b++) begin : g_lane
    assign cap_lane[b] = data_word[b];
    assign lane_pri[b] = state_reg.word[b];
    assign lane_cmp[b] = ~state_reg.word[b];
  end

  // ---------------------------------------------------------------
  // power sequencing terms
  // ---------------------------------------------------------------
  // undriven pin reads as low through the pull-down
  assign sleep_eff = sleep_in_driven & sleep_in;
  // entry edge plus count edges stay inside the 50 ns bound
  assign down_done = (state_reg.cnt >= 10'(DACIL_DOWN_CYC - 2));
  assign wake_done = (state_reg.cnt >= 10'(DACIL_WAKE_CYC - 1));
  assign go_down   = sleep_eff && ((state_reg.pwr == DACIL_PWR_ON) ||
                                   (state_reg.pwr == DACIL_PWR_WAKE));
  assign go_sleep  = (state_reg.pwr == DACIL_PWR_DOWN) && down_done;
  assign go_wake   = (state_reg.pwr == DACIL_PWR_SLEEP) && !sleep_eff;
  assign go_on     = (state_reg.pwr == DACIL_PWR_WAKE) && !sleep_eff && wake_done;

  // ---------------------------------------------------------------
  // clock receiver strap decode
  // ---------------------------------------------------------------
  // floating select reads as both straps low; low wins if both set
  assign strap_mode = clock_receiver_select_low  ? DACIL_CLK_SINGLE :
                      clock_receiver_select_high ? DACIL_CLK_DIFF   :
                                                   DACIL_CLK_TERM;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;

    // ---------------------------------------------------------------
    // sample capture
    // ---------------------------------------------------------------
    // one flop stage per edge, whole word at once; edge triggered, so
    // duty cycle does not matter
    state_next.word = cap_lane[DACIL_MSB_POS:DACIL_LSB_POS];

    // ---------------------------------------------------------------
    // power sequencing
    // ---------------------------------------------------------------
    case (state_reg.pwr)
      DACIL_PWR_ON: begin
        if (go_down) begin
          state_next.pwr = DACIL_PWR_DOWN;
        end else begin
          state_next.pwr = DACIL_PWR_ON;
        end
        state_next.cnt = 10'h000;
      end

      DACIL_PWR_DOWN: begin
        // sleep is not looked at here; the drop always runs to its end
        state_next.cnt = state_reg.cnt + 10'h001;
        if (go_sleep) begin
          state_next.pwr = DACIL_PWR_SLEEP;
        end else begin
          state_next.pwr = DACIL_PWR_DOWN;
        end
      end

      DACIL_PWR_SLEEP: begin
        state_next.cnt = 10'h000;
        if (go_wake) begin
          state_next.pwr = DACIL_PWR_WAKE;
        end else begin
          state_next.pwr = DACIL_PWR_SLEEP;
        end
      end

      DACIL_PWR_WAKE: begin
        if (go_down) begin
          // sleep during wake starts the power-down over
          state_next.pwr = DACIL_PWR_DOWN;
          state_next.cnt = 10'h000;
        end else if (go_on) begin
          state_next.pwr = DACIL_PWR_ON;
          state_next.cnt = 10'h000;
        end else begin
          state_next.pwr = DACIL_PWR_WAKE;
          state_next.cnt = state_reg.cnt + 10'h001;
        end
      end

      default: begin
        state_next.pwr = DACIL_PWR_SLEEP;
        state_next.cnt = 10'h000;
      end
    endcase

    // ---------------------------------------------------------------
    // output gating
    // ---------------------------------------------------------------
    // current off as soon as sleep is seen, not after settling
    state_next.powered = (state_next.pwr == DACIL_PWR_ON) && !sleep_eff;
    if (state_next.powered) begin
      state_next.out.primary       = lane_pri;
      state_next.out.complementary = lane_cmp;
    end else begin
      state_next.out.primary       = DACIL_CODE_ZERO;
      state_next.out.complementary = DACIL_CODE_ZERO;
    end

    // ---------------------------------------------------------------
    // receiver configuration
    // ---------------------------------------------------------------
    // straps are static; followed every cycle rather than caught once
    state_next.mode = strap_mode;
    // negative input ignored in single-ended mode
    case (strap_mode)
      DACIL_CLK_SINGLE: begin
        state_next.term_en   = 1'b0;
        state_next.neg_in_en = 1'b0;
      end
      DACIL_CLK_DIFF: begin
        state_next.term_en   = 1'b0;
        state_next.neg_in_en = 1'b1;
      end
      DACIL_CLK_TERM: begin
        state_next.term_en   = 1'b1;
        state_next.neg_in_en = 1'b1;
      end
      default: begin
        state_next.term_en   = 1'b0;
        state_next.neg_in_en = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      // power-up goes through the wake delay like a release from sleep
      state_reg.word              <= 10'h000;
      state_reg.out.primary       <= 10'h000;
      state_reg.out.complementary <= 10'h000;
      state_reg.pwr               <= DACIL_PWR_WAKE;
      state_reg.cnt               <= 10'h000;
      state_reg.powered           <= 1'b0;
      state_reg.mode              <= DACIL_CLK_SINGLE;
      state_reg.term_en           <= 1'b0;
      state_reg.neg_in_en         <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign primary_current_out       = state_reg.out.primary;
  assign complementary_current_out = state_reg.out.complementary;
  assign output_enabled            = state_reg.powered;
  assign clk_mode                  = state_reg.mode;
  assign clk_term_en               = state_reg.term_en;
  assign clk_neg_in_en             = state_reg.neg_in_en;

endmodule : dacil_core
`default_nettype wire

// ===== verif/dacil_core_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dacil_core_properties
  import dacil_pkg::*;
(
  // watched ports
  input wire logic            clk_sys,
  input wire logic            rst_n,
  input wire logic [9:0]      data_word,
  input wire logic            clock_receiver_select_low,
  input wire logic            clock_receiver_select_high,
  input wire logic            sleep_in,
  input wire logic            sleep_in_driven,
  input wire logic [9:0]      primary_current_out,
  input wire logic [9:0]      complementary_current_out,
  input wire logic            output_enabled,
  input wire dacil_clk_mode_t clk_mode,
  input wire logic            clk_term_en,
  input wire logic            clk_neg_in_en
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_slp; sleep_in && sleep_in_driven; endsequence
  a_word_latch: assert property (output_enabled && $past(output_enabled) |->
    primary_current_out == $past(data_word, 2)) else $error("word not latched");
  a_cmp_sum: assert property (output_enabled |->
    complementary_current_out == 10'h3FF - primary_current_out) else $error("bad split");
  a_off_zero: assert property (!output_enabled |->
    primary_current_out == 10'h000 && complementary_current_out == 10'h000)
    else $error("current on");
  a_sleep_off: assert property (s_slp |=> !output_enabled) else $error("no power-down");
  a_pull_down: assert property (output_enabled && !sleep_in_driven |=> output_enabled)
    else $error("floating sleep slept");
  a_wake_hold: assert property (s_slp ##1 !sleep_in |=> !output_enabled [*8])
    else $error("woke too soon");
  a_mode_single: assert property (clock_receiver_select_low |=>
    clk_mode == DACIL_CLK_SINGLE && !clk_neg_in_en) else $error("single mode");
  a_mode_diff: assert property (!clock_receiver_select_low && clock_receiver_select_high |=>
    clk_mode == DACIL_CLK_DIFF && !clk_term_en && clk_neg_in_en) else $error("diff mode");
  a_mode_term: assert property (!clock_receiver_select_low &&
    !clock_receiver_select_high |=> clk_mode == DACIL_CLK_TERM && clk_term_en && clk_neg_in_en)
    else $error("term mode");
endmodule : dacil_core_properties
bind dacil_core dacil_core_properties u_chk (.*);
`default_nettype wire

// ===== verif/dacil_src.sv
`timescale 1ns/1ps
`default_nettype none
module dacil_src (
  input  wire logic       clk_sys,
  input  wire logic       fix_en,
  input  wire logic [9:0] fix_val,
  output logic [9:0]      data_word
);
  // change away from the capturing edge
  always @(negedge clk_sys) data_word <= fix_en ? fix_val : 10'($urandom);
endmodule : dacil_src
`default_nettype wire

// ===== verif/dac_input_latch_sleep_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dac_input_latch_sleep_tb
  import dacil_pkg::*;
;
  logic clk_sys = 0, rst_n = 0, lo = 0, hi = 0, slp = 0, drv = 1, fix_en = 1;
  logic [9:0] fix_val = 10'h000, dw, pri, cmp, h1, h2;
  logic oe, ten, nen;
  dacil_clk_mode_t md;
  int error_cnt = 0, n_checks = 0, i, m;
  dacil_src src (.clk_sys(clk_sys), .fix_en(fix_en), .fix_val(fix_val), .data_word(dw));
  dacil_core dut (.clk_sys(clk_sys), .rst_n(rst_n), .data_word(dw),
    .clock_receiver_select_low(lo), .clock_receiver_select_high(hi), .sleep_in(slp),
    .sleep_in_driven(drv), .primary_current_out(pri), .complementary_current_out(cmp),
    .output_enabled(oe), .clk_mode(md), .clk_term_en(ten), .clk_neg_in_en(nen));
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    h1 <= dw;
    h2 <= h1;
  end
  function automatic logic [9:0] exp_cmp(logic [9:0] w);
    return 10'h3FF - w;
  endfunction : exp_cmp
  task automatic chk(logic [9:0] got, logic [9:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  initial begin
    #200000;
    error_cnt++;
    stop_test();
  end
  initial begin
    void'($urandom(75927));
    repeat (16) @(negedge clk_sys);
    rst_n = 1;
    repeat (480) @(negedge clk_sys);
    chk(10'(oe), 10'h000);
    repeat (40) @(negedge clk_sys);
    chk(10'(oe), 10'h001);
    $display("wake done");
    for (i = 0; i < 300; i++) begin
      @(negedge clk_sys);
      fix_en <= (i < 8);
      fix_val <= (i[0]) ? 10'h3FF : 10'(i * 10'h155);
      chk(pri, h2);
      chk(cmp, exp_cmp(h2));
    end
    $display("stream done");
    for (m = 0; m < 3; m++) begin
      @(negedge clk_sys);
      lo = m == 0;
      hi = m == 1;
      repeat (2) @(negedge clk_sys);
      chk(10'(md), (m == 0) ? 10'(DACIL_CLK_SINGLE) :
          10'(m == 1 ? DACIL_CLK_DIFF : DACIL_CLK_TERM));
      chk(10'({ten, nen}), (m == 0) ? 10'h000 : (m == 1) ? 10'h001 : 10'h003);
    end
    $display("modes done");
    slp = 1;
    drv = 0;
    repeat (20) @(negedge clk_sys);
    chk(10'(oe), 10'h001);
    drv = 1;
    @(negedge clk_sys);
    chk({10'(oe) | pri}, 10'h000);
    chk(cmp, 10'h000);
    repeat (5) @(negedge clk_sys);
    slp = 0;
    repeat (100) @(negedge clk_sys);
    chk(10'(oe), 10'h000);
    // sleep again mid-wake: power-down starts over, then a full wake
    slp = 1;
    @(negedge clk_sys);
    slp = 0;
    for (i = 0; i < 600 && oe !== 1'b1; i++) @(negedge clk_sys);
    chk(10'(oe), 10'h001);
    chk(10'(i >= DACIL_WAKE_CYC && i <= DACIL_WAKE_CYC + DACIL_DOWN_CYC), 10'h001);
    $display("sleep done");
    stop_test();
  end
endmodule : dac_input_latch_sleep_tb
`default_nettype wire
